/* verilog/erf_pkg.sv */
package erf_pkg;

  // bus geometry
  localparam int ERF_AW = 8;
  localparam int ERF_DW = 32;

  // register byte offsets
  localparam logic [7:0] ERF_OFS_FORCE  = 8'h00;
  localparam logic [7:0] ERF_OFS_STATUS = 8'h04;
  localparam logic [7:0] ERF_OFS_MASK   = 8'h08;
  localparam logic [7:0] ERF_OFS_RAW    = 8'h0c;

  // field positions shared by force, status, mask and raw
  localparam int ERF_POS_SIG_RELOAD = 24;
  localparam int ERF_POS_SIG_FAIL   = 23;
  localparam int ERF_POS_DUAL_XTAL  = 22;
  localparam int ERF_POS_XTAL_SWAP  = 21;
  localparam int ERF_POS_FREQ_HI    = 20;
  localparam int ERF_POS_FREQ_LO    = 9;
  localparam int ERF_POS_ST_B       = 8;
  localparam int ERF_POS_ST_A       = 7;
  localparam int ERF_POS_PPM_ERR    = 6;
  localparam int ERF_POS_PPM_WARN   = 5;
  localparam int ERF_POS_LOS_B      = 4;
  localparam int ERF_POS_LOS_A      = 3;
  localparam int ERF_POS_LOL        = 2;
  localparam int ERF_POS_RSVD       = 1;
  localparam int ERF_POS_POST       = 0;

  // implemented bits: 24..2 and 0, bit 1 and 31..25 absent
  localparam logic [31:0] ERF_VALID_BITS = 32'h01fffffd;

  // reset values
  localparam logic [31:0] ERF_STATUS_RST = 32'h00000000;
  localparam logic [31:0] ERF_MASK_RST   = 32'h00000000;
  localparam logic [31:0] ERF_RDATA_RST  = 32'h00000000;

  // monitored conditions, msb first in force register order
  typedef struct packed {
    logic        sig_reload_fail;
    logic        sig_fail;
    logic        dual_xtal_fail;
    logic        xtal_switch;
    logic [11:0] clock_frequency_monitor_event;
    logic        crystal_b_short_term_error;
    logic        crystal_a_short_term_error;
    logic        ppm_error;
    logic        ppm_warning;
    logic        crystal_b_signal_loss;
    logic        crystal_a_signal_loss;
    logic        synth_lock_loss;
    logic        self_test_fail;
  } erf_evt_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } erf_bus_t;

endpackage

/* verilog/erf_event_force.sv */
`timescale 1ns/1ps

// Function
// - A one written to force bit 24 sets the signature reload failure status bit.
// - A one written to force bit 23 sets the register signature failure status bit.
// - A one written to force bit 22 sets the dual crystal failure status bit.
// - A one written to force bit 21 sets the crystal changeover status bit.
// - Force bits 20 down to 9 set clock frequency monitor events 11 down to 0.
// - Force bits 8 and 7 set the crystal b and crystal a short-term error bits.
// - A one written to force bit 6 sets the crystal frequency deviation error bit.
// - A one written to force bit 5 sets the crystal frequency deviation warning bit.
// - Force bits 4 and 3 set the crystal b and crystal a signal loss bits.
// - A one written to force bit 2 sets the synthesizer loss-of-lock status bit.
// - A one written to force bit 0 sets the self-test failure status bit.
// - The force register stores nothing and every field reads back as zero.
// - A forced status bit stays set until software writes a one to that status bit.
module erf_event_force (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire erf_pkg::erf_bus_t bus,
  input  wire erf_pkg::erf_evt_t hw_event,
  output logic [31:0]            rdata,
  output erf_pkg::erf_evt_t      status_out,
  output logic                   irq
);
  import erf_pkg::*;

  // flatten a condition struct onto register bit positions
  function automatic logic [31:0] evt_to_vec(input erf_evt_t e);
    logic [31:0] v;
    v = 32'h00000000;
    v[ERF_POS_SIG_RELOAD] = e.sig_reload_fail;
    v[ERF_POS_SIG_FAIL] = e.sig_fail;
    v[ERF_POS_DUAL_XTAL] = e.dual_xtal_fail;
    v[ERF_POS_XTAL_SWAP] = e.xtal_switch;
    v[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO] = e.clock_frequency_monitor_event;
    v[ERF_POS_ST_B] = e.crystal_b_short_term_error;
    v[ERF_POS_ST_A] = e.crystal_a_short_term_error;
    v[ERF_POS_PPM_ERR] = e.ppm_error;
    v[ERF_POS_PPM_WARN] = e.ppm_warning;
    v[ERF_POS_LOS_B] = e.crystal_b_signal_loss;
    v[ERF_POS_LOS_A] = e.crystal_a_signal_loss;
    v[ERF_POS_LOL] = e.synth_lock_loss;
    v[ERF_POS_POST] = e.self_test_fail;
    return v;
  endfunction

  // rebuild a condition struct from register bit positions
  function automatic erf_evt_t vec_to_evt(input logic [31:0] v);
    erf_evt_t e;
    e.sig_reload_fail = v[ERF_POS_SIG_RELOAD];
    e.sig_fail = v[ERF_POS_SIG_FAIL];
    e.dual_xtal_fail = v[ERF_POS_DUAL_XTAL];
    e.xtal_switch = v[ERF_POS_XTAL_SWAP];
    e.clock_frequency_monitor_event = v[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO];
    e.crystal_b_short_term_error = v[ERF_POS_ST_B];
    e.crystal_a_short_term_error = v[ERF_POS_ST_A];
    e.ppm_error = v[ERF_POS_PPM_ERR];
    e.ppm_warning = v[ERF_POS_PPM_WARN];
    e.crystal_b_signal_loss = v[ERF_POS_LOS_B];
    e.crystal_a_signal_loss = v[ERF_POS_LOS_A];
    e.synth_lock_loss = v[ERF_POS_LOL];
    e.self_test_fail = v[ERF_POS_POST];
    return e;
  endfunction

  // address match for one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        irq_q;
  logic        irq_d;
  logic [31:0] force_vec;
  logic [31:0] hw_vec;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic        wr_force;
  logic        wr_status;
  logic        wr_mask;

  // one latch per monitored condition
  logic        sig_reload_q;
  logic        sig_fail_q;
  logic        dual_xtal_q;
  logic        xtal_swap_q;
  logic [11:0] freq_evt_q;
  logic        st_b_q;
  logic        st_a_q;
  logic        ppm_err_q;
  logic        ppm_warn_q;
  logic        los_b_q;
  logic        los_a_q;
  logic        lock_loss_q;
  logic        self_test_q;

  // write decode
  assign wr_force = bus.wr & hit(bus.addr, ERF_OFS_FORCE);
  assign wr_status = bus.wr & hit(bus.addr, ERF_OFS_STATUS);
  assign wr_mask = bus.wr & hit(bus.addr, ERF_OFS_MASK);

  // one-cycle set pulses from a force write, never stored
  always_comb begin
    force_vec = 32'h00000000;
    if (wr_force) begin
      force_vec[ERF_POS_SIG_RELOAD] = bus.wdata[ERF_POS_SIG_RELOAD];
      force_vec[ERF_POS_SIG_FAIL] = bus.wdata[ERF_POS_SIG_FAIL];
      force_vec[ERF_POS_DUAL_XTAL] = bus.wdata[ERF_POS_DUAL_XTAL];
      force_vec[ERF_POS_XTAL_SWAP] = bus.wdata[ERF_POS_XTAL_SWAP];
      // bit 20 is clock 11, bit 9 is clock 0
      force_vec[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO] =
        bus.wdata[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO];
      force_vec[ERF_POS_ST_B] = bus.wdata[ERF_POS_ST_B];
      force_vec[ERF_POS_ST_A] = bus.wdata[ERF_POS_ST_A];
      force_vec[ERF_POS_PPM_ERR] = bus.wdata[ERF_POS_PPM_ERR];
      force_vec[ERF_POS_PPM_WARN] = bus.wdata[ERF_POS_PPM_WARN];
      force_vec[ERF_POS_LOS_B] = bus.wdata[ERF_POS_LOS_B];
      force_vec[ERF_POS_LOS_A] = bus.wdata[ERF_POS_LOS_A];
      force_vec[ERF_POS_LOL] = bus.wdata[ERF_POS_LOL];
      force_vec[ERF_POS_POST] = bus.wdata[ERF_POS_POST];
    end
  end

  // live monitor conditions on register positions
  assign hw_vec = evt_to_vec(hw_event) & ERF_VALID_BITS;

  // a zero in the force word adds nothing to the set term
  assign set_vec = (hw_vec | force_vec) & ERF_VALID_BITS;

  // write-one-to-clear term for the status register
  assign clr_vec = wr_status ? (bus.wdata & ERF_VALID_BITS) : 32'h00000000;

  // sticky status: set wins over a clear in the same cycle
  always_comb begin
    status_d = ((status_q & ~clr_vec) | set_vec) & ERF_VALID_BITS;
  end

  // field latches gathered onto register positions, gaps read zero
  always_comb begin
    status_q = 32'h00000000;
    status_q[ERF_POS_SIG_RELOAD] = sig_reload_q;
    status_q[ERF_POS_SIG_FAIL] = sig_fail_q;
    status_q[ERF_POS_DUAL_XTAL] = dual_xtal_q;
    status_q[ERF_POS_XTAL_SWAP] = xtal_swap_q;
    status_q[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO] = freq_evt_q;
    status_q[ERF_POS_ST_B] = st_b_q;
    status_q[ERF_POS_ST_A] = st_a_q;
    status_q[ERF_POS_PPM_ERR] = ppm_err_q;
    status_q[ERF_POS_PPM_WARN] = ppm_warn_q;
    status_q[ERF_POS_LOS_B] = los_b_q;
    status_q[ERF_POS_LOS_A] = los_a_q;
    status_q[ERF_POS_LOL] = lock_loss_q;
    status_q[ERF_POS_POST] = self_test_q;
  end

  // signature reload failure latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sig_reload_q <= ERF_STATUS_RST[ERF_POS_SIG_RELOAD];
    end else begin
      sig_reload_q <= status_d[ERF_POS_SIG_RELOAD];
    end
  end

  // register signature failure latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sig_fail_q <= ERF_STATUS_RST[ERF_POS_SIG_FAIL];
    end else begin
      sig_fail_q <= status_d[ERF_POS_SIG_FAIL];
    end
  end

  // dual crystal failure latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dual_xtal_q <= ERF_STATUS_RST[ERF_POS_DUAL_XTAL];
    end else begin
      dual_xtal_q <= status_d[ERF_POS_DUAL_XTAL];
    end
  end

  // crystal changeover latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xtal_swap_q <= ERF_STATUS_RST[ERF_POS_XTAL_SWAP];
    end else begin
      xtal_swap_q <= status_d[ERF_POS_XTAL_SWAP];
    end
  end

  // output clock monitor latches, msb is clock 11
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      freq_evt_q <= ERF_STATUS_RST[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO];
    end else begin
      freq_evt_q <= status_d[ERF_POS_FREQ_HI:ERF_POS_FREQ_LO];
    end
  end

  // crystal b short-term error latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_b_q <= ERF_STATUS_RST[ERF_POS_ST_B];
    end else begin
      st_b_q <= status_d[ERF_POS_ST_B];
    end
  end

  // crystal a short-term error latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_a_q <= ERF_STATUS_RST[ERF_POS_ST_A];
    end else begin
      st_a_q <= status_d[ERF_POS_ST_A];
    end
  end

  // frequency deviation error latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ppm_err_q <= ERF_STATUS_RST[ERF_POS_PPM_ERR];
    end else begin
      ppm_err_q <= status_d[ERF_POS_PPM_ERR];
    end
  end

  // frequency deviation warning latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ppm_warn_q <= ERF_STATUS_RST[ERF_POS_PPM_WARN];
    end else begin
      ppm_warn_q <= status_d[ERF_POS_PPM_WARN];
    end
  end

  // crystal b signal loss latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      los_b_q <= ERF_STATUS_RST[ERF_POS_LOS_B];
    end else begin
      los_b_q <= status_d[ERF_POS_LOS_B];
    end
  end

  // crystal a signal loss latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      los_a_q <= ERF_STATUS_RST[ERF_POS_LOS_A];
    end else begin
      los_a_q <= status_d[ERF_POS_LOS_A];
    end
  end

  // synthesizer loss-of-lock latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_loss_q <= ERF_STATUS_RST[ERF_POS_LOL];
    end else begin
      lock_loss_q <= status_d[ERF_POS_LOL];
    end
  end

  // self-test failure latch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      self_test_q <= ERF_STATUS_RST[ERF_POS_POST];
    end else begin
      self_test_q <= status_d[ERF_POS_POST];
    end
  end

  // interrupt mask, one enables the matching status bit
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = bus.wdata & ERF_VALID_BITS;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= ERF_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // level interrupt follows the next status and mask together
  assign irq_d = |(status_d & mask_d);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // read mux, data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h00000000;
    if (bus.rd) begin
      case (bus.addr)
        ERF_OFS_FORCE: begin
          rdata_d = 32'h00000000;
        end
        ERF_OFS_STATUS: begin
          rdata_d = status_q & ERF_VALID_BITS;
        end
        ERF_OFS_MASK: begin
          rdata_d = mask_q & ERF_VALID_BITS;
        end
        ERF_OFS_RAW: begin
          rdata_d = hw_vec;
        end
        default: begin
          rdata_d = 32'h00000000; // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= ERF_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign rdata = rdata_q;
  assign irq = irq_q;
  assign status_out = vec_to_evt(status_q);

endmodule

/* testbench/erf_event_force_assertions.sv */
`timescale 1ns/1ps
module erf_event_force_assertions
  import erf_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire erf_pkg::erf_bus_t bus,
  input wire erf_pkg::erf_evt_t hw_event,
  input wire logic [31:0]       rdata,
  input wire erf_pkg::erf_evt_t status_out,
  input wire logic              irq
);
  logic [23:0] wmap;
  logic [31:0] sword;
  // write data folded onto the status layout, status as a bus word
  assign wmap  = {bus.wdata[24:2], bus.wdata[0]};
  assign sword = {7'h00, status_out[23:1], 1'b0, status_out[0]};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_force_wr; bus.wr && bus.addr == ERF_OFS_FORCE; endsequence
  sequence s_force_rd; bus.rd && bus.addr == ERF_OFS_FORCE; endsequence
  sequence s_stat_rd; bus.rd && bus.addr == ERF_OFS_STATUS; endsequence
  sequence s_clr_wr; bus.wr && bus.addr == ERF_OFS_STATUS && hw_event == '0; endsequence
  property p_force_set; s_force_wr |=> (status_out & $past(wmap)) == $past(wmap); endproperty
  property p_force_zero; s_force_rd |=> rdata == 32'h0; endproperty
  property p_rd_idle; !bus.rd |=> rdata == 32'h0; endproperty
  property p_sticky;
    !(bus.wr && bus.addr == ERF_OFS_STATUS) |=> (status_out & $past(status_out)) == $past(status_out);
  endproperty
  property p_clear; s_clr_wr |=> (status_out & $past(wmap)) == 24'h0; endproperty
  property p_hw_set; hw_event != '0 |=> (status_out & $past(hw_event)) == $past(hw_event); endproperty
  property p_stat_rd; s_stat_rd |=> rdata == $past(sword); endproperty
  property p_irq_src; irq |-> status_out != '0; endproperty
  a_force_set: assert property (p_force_set) else $error("forced bit not set");
  a_force_zero: assert property (p_force_zero) else $error("force read not zero");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_sticky: assert property (p_sticky) else $error("status bit fell");
  a_clear: assert property (p_clear) else $error("status not cleared");
  a_hw_set: assert property (p_hw_set) else $error("event not latched");
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
  a_irq_src: assert property (p_irq_src) else $error("irq without status");
endmodule
bind erf_event_force erf_event_force_assertions u_chk (.clock(clock), .rst_b(rst_b), .bus(bus),
  .hw_event(hw_event), .rdata(rdata), .status_out(status_out), .irq(irq));

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import erf_pkg::*;
  logic        clock;
  logic        rst_b;
  erf_bus_t    bus;
  erf_evt_t    hw_event;
  logic [31:0] rdata;
  erf_evt_t    status_out;
  logic        irq;
  logic [31:0] status_word;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  erf_event_force u_dut (.clock(clock), .rst_b(rst_b), .bus(bus), .hw_event(hw_event),
    .rdata(rdata), .status_out(status_out), .irq(irq));
  // latched status laid out as a register word, bits 31..25 and 1 empty
  assign status_word = {7'h00, status_out[23:1], 1'b0, status_out[0]};
  // 40 ns clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk_word(n, e, rdata);
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end
  // main sequence
  initial begin
    bus = '0;
    hw_event = '0;
    rst_b = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd("mask", ERF_OFS_MASK, 32'h0);
    for (int i = 0; i < 32; i++) begin
      wr(ERF_OFS_FORCE, 32'h1 << i);
      chk_word("status_out", (32'h1 << i) & ERF_VALID_BITS, status_word);
      rd("status", ERF_OFS_STATUS, (32'h1 << i) & ERF_VALID_BITS);
      rd("force", ERF_OFS_FORCE, 32'h0);
      wr(ERF_OFS_STATUS, 32'hffffffff);
      rd("status", ERF_OFS_STATUS, 32'h0);
    end
    wr(ERF_OFS_FORCE, 32'h00100000);
    chk_bit("clock 11 event", 1'b1, status_out.clock_frequency_monitor_event[11]);
    chk_bit("clock 0 event", 1'b0, status_out.clock_frequency_monitor_event[0]);
    wr(ERF_OFS_STATUS, 32'h00100000);
    wr(ERF_OFS_MASK, 32'h00000004);
    wr(ERF_OFS_FORCE, 32'h00000004);
    chk_bit("irq", 1'b1, irq);
    chk_bit("synth_lock_loss", 1'b1, status_out.synth_lock_loss);
    wr(ERF_OFS_FORCE, 32'h0);
    wr(ERF_OFS_STATUS, 32'h00000010);
    rd("status", ERF_OFS_STATUS, 32'h00000004);
    wr(ERF_OFS_MASK, 32'h0);
    chk_bit("irq", 1'b0, irq);
    wr(ERF_OFS_FORCE, 32'hffffffff);
    rd("force", ERF_OFS_FORCE, 32'h0);
    wr(ERF_OFS_STATUS, 32'h00000004);
    rd("status", ERF_OFS_STATUS, ERF_VALID_BITS & 32'hfffffffb);
    wr(ERF_OFS_STATUS, 32'hffffffff);
    rd("unmapped", 8'h40, 32'h0);
    // live events seen raw, then latched
    @(posedge clock);
    hw_event <= '1;
    rd("raw", ERF_OFS_RAW, ERF_VALID_BITS);
    // a clear while the events still stand loses to the set
    wr(ERF_OFS_STATUS, 32'hffffffff);
    @(posedge clock);
    hw_event <= '0;
    rd("status", ERF_OFS_STATUS, ERF_VALID_BITS);
    test_done();
  end
endmodule
